// ---- hw/cza_defines.svh ----
`ifndef CZA_DEFINES_SVH
`define CZA_DEFINES_SVH

// Register byte offsets
`define CZA_OFF_CTRL      8'h00
`define CZA_OFF_JAM_TIME  8'h04
`define CZA_OFF_CLR_TIME  8'h08
`define CZA_OFF_STATUS    8'h0C
`define CZA_OFF_NEIGHBOUR 8'h10
`define CZA_OFF_CMD       8'h14

// Control fields
`define CZA_CTRL_FLEX_EN  0
`define CZA_CTRL_ARR_EN   1
`define CZA_CTRL_SAC_EN   2
`define CZA_CTRL_RESET    32'h0000_0007

// Command fields (write one to act)
`define CZA_CMD_RECOVER   0

// Timer values are in milliseconds
`define CZA_CLK_HZ        200_000_000
`define CZA_TICK_MS       1
`define CZA_TICK_CYCLES   ((`CZA_CLK_HZ / 1000) * `CZA_TICK_MS)
`define CZA_JAM_MS        5000
`define CZA_CLR_MS        5000
`define CZA_REV_MS        1000
`define CZA_ATTEMPTS      3
`define CZA_NEIGHBOUR_RST 32'h0000_0000

`endif

// ---- hw/cza_pkg.sv ----
package cza_pkg;

	typedef enum logic [1:0] {
		CZA_HTRANS_IDLE   = 2'h0,
		CZA_HTRANS_BUSY   = 2'h1,
		CZA_HTRANS_NONSEQ = 2'h2,
		CZA_HTRANS_SEQ    = 2'h3
	} cza_htrans_t;

	typedef struct packed {
		logic        hsel;
		logic [31:0] haddr;
		cza_htrans_t htrans;
		logic        hwrite;
		logic [2:0]  hsize;
		logic [31:0] hwdata;
		logic        hready;
	} cza_ahb_req_t;

	typedef struct packed {
		logic [31:0] hrdata;
		logic        hreadyout;
		logic        hresp;
	} cza_ahb_rsp_t;

	// Status exchanged with neighbouring zones
	typedef struct packed {
		logic clear;
		logic arrived;
	} cza_link_t;

	typedef struct packed {
		logic fwd;
		logic rev;
	} cza_motor_t;

	typedef enum {
		CZA_SJ_IDLE,
		CZA_SJ_WATCH,
		CZA_SJ_REVERSE,
		CZA_SJ_WAIT,
		CZA_SJ_FORWARD,
		CZA_SJ_STUCK
	} cza_sj_state_t;

endpackage

// ---- hw/cza_zone.sv ----
// Added by the designer: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "cza_defines.svh"

module cza_zone
	import cza_pkg::*;
(
	input  wire logic         clk_sys,
	input  wire logic         reset,
	input  wire cza_ahb_req_t ahb_req,
	output cza_ahb_rsp_t      ahb_rsp,
	input  wire logic         zone_photo_eye,
	input  wire logic         downstream_photo_eye,
	input  wire cza_link_t    downstream_link,
	input  wire logic         upstream_release,
	input  wire logic         neighbour_update,
	input  wire logic [31:0]  neighbour_data,
	output cza_link_t         upstream_link,
	output cza_motor_t        motor,
	output logic              sensor_led
);

	logic [31:0]   ctrl_reg;
	logic [31:0]   jam_time_reg;
	logic [31:0]   clr_time_reg;
	logic [31:0]   neighbour_reg;
	logic [31:0]   rdata_reg;
	logic          wr_pend_reg;
	logic [7:0]    wr_addr_reg;
	logic          recover_req;
	logic [31:0]   tick_cnt_reg;
	logic          tick;
	logic          eye_q_reg;
	logic          flex_reg;
	logic          pend_reg;
	logic          arr_jam_reg;
	logic [31:0]   arr_cnt_reg;
	logic          releasing;
	logic          hold;
	cza_sj_state_t sj_state_reg;
	logic [31:0]   sj_cnt_reg;
	logic [1:0]    tries_reg;
	logic [8:0]    blink_reg;

	// Bus slave: zero wait states, writes land at the data phase
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
			rdata_reg   <= 32'h0000_0000;
		end else if (ahb_req.hready) begin
			wr_pend_reg <= ahb_req.hsel && ahb_req.htrans[1] && ahb_req.hwrite;
			wr_addr_reg <= ahb_req.haddr[7:0];
			if (ahb_req.hsel && ahb_req.htrans[1] && !ahb_req.hwrite) begin
				case (ahb_req.haddr[7:0])
					`CZA_OFF_CTRL:      rdata_reg <= ctrl_reg;
					`CZA_OFF_JAM_TIME:  rdata_reg <= jam_time_reg;
					`CZA_OFF_CLR_TIME:  rdata_reg <= clr_time_reg;
					`CZA_OFF_NEIGHBOUR: rdata_reg <= neighbour_reg;
					`CZA_OFF_STATUS: begin
						rdata_reg <= {24'h0, tries_reg, sj_state_reg == CZA_SJ_STUCK,
							sj_state_reg != CZA_SJ_IDLE && sj_state_reg != CZA_SJ_WATCH,
							arr_jam_reg, pend_reg, flex_reg, zone_photo_eye};
					end
					default:            rdata_reg <= 32'h0000_0000;
				endcase
			end
		end
	end

	assign ahb_rsp.hrdata    = rdata_reg;
	assign ahb_rsp.hreadyout = 1'b1;
	assign ahb_rsp.hresp     = 1'b0;
	assign recover_req = wr_pend_reg && wr_addr_reg == `CZA_OFF_CMD
		&& ahb_req.hwdata[`CZA_CMD_RECOVER];

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			ctrl_reg     <= `CZA_CTRL_RESET;
			jam_time_reg <= `CZA_JAM_MS;
			clr_time_reg <= `CZA_CLR_MS;
		end else if (wr_pend_reg) begin
			case (wr_addr_reg)
				`CZA_OFF_CTRL:     ctrl_reg     <= ahb_req.hwdata & `CZA_CTRL_RESET;
				`CZA_OFF_JAM_TIME: jam_time_reg <= ahb_req.hwdata;
				`CZA_OFF_CLR_TIME: clr_time_reg <= ahb_req.hwdata;
				default: ;
			endcase
		end
	end

	// Neighbour data follows every line parameter change, or software
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			neighbour_reg <= `CZA_NEIGHBOUR_RST;
		end else if (neighbour_update) begin
			neighbour_reg <= neighbour_data;
		end else if (wr_pend_reg && wr_addr_reg == `CZA_OFF_NEIGHBOUR) begin
			neighbour_reg <= ahb_req.hwdata;
		end
	end

	// Millisecond time base for the 32-bit second-scale counters
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			tick_cnt_reg <= 32'h0000_0000;
		end else if (tick_cnt_reg == 32'(`CZA_TICK_CYCLES - 1)) begin
			tick_cnt_reg <= 32'h0000_0000;
		end else begin
			tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
		end
	end
	assign tick = tick_cnt_reg == 32'(`CZA_TICK_CYCLES - 1);

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			eye_q_reg <= 1'b0;
		end else begin
			eye_q_reg <= zone_photo_eye;
		end
	end

	// Long carton: own sensor still blocked while downstream eye is too
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			flex_reg <= 1'b0;
		end else if (!ctrl_reg[`CZA_CTRL_FLEX_EN]) begin
			flex_reg <= 1'b0;
		end else if (releasing && zone_photo_eye && downstream_photo_eye) begin
			flex_reg <= 1'b1;
		end else if (flex_reg && !zone_photo_eye && downstream_photo_eye
			&& downstream_link.arrived) begin
			flex_reg <= 1'b0;
		end
	end

	// Arrival confirmation wait and arrival jam
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			pend_reg    <= 1'b0;
			arr_jam_reg <= 1'b0;
			arr_cnt_reg <= 32'h0000_0000;
		end else if (arr_jam_reg) begin
			if (tick) begin
				arr_cnt_reg <= arr_cnt_reg + 32'h0000_0001;
			end
			if (arr_cnt_reg >= clr_time_reg) begin
				arr_jam_reg <= 1'b0;
				arr_cnt_reg <= 32'h0000_0000;
			end
		end else if (pend_reg) begin
			if (downstream_link.arrived) begin
				pend_reg    <= 1'b0;
				arr_cnt_reg <= 32'h0000_0000;
			end else if (arr_cnt_reg >= jam_time_reg) begin
				pend_reg    <= 1'b0;
				arr_jam_reg <= ctrl_reg[`CZA_CTRL_ARR_EN];
				arr_cnt_reg <= 32'h0000_0000;
			end else if (tick) begin
				arr_cnt_reg <= arr_cnt_reg + 32'h0000_0001;
			end
		end else if (eye_q_reg && !zone_photo_eye && motor.fwd) begin
			pend_reg    <= 1'b1;
			arr_cnt_reg <= 32'h0000_0000;
		end
	end

	// Release gate: downstream clear, no long carton, no pending or jam
	assign hold = flex_reg || pend_reg || arr_jam_reg;
	assign releasing = zone_photo_eye && downstream_link.clear && !hold
		&& (sj_state_reg == CZA_SJ_IDLE || sj_state_reg == CZA_SJ_WATCH);

	// Sensor jam watch and recovery sequence
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			sj_state_reg <= CZA_SJ_IDLE;
			sj_cnt_reg   <= 32'h0000_0000;
			tries_reg    <= 2'h0;
		end else begin
			case (sj_state_reg)
				CZA_SJ_IDLE: begin
					sj_cnt_reg <= 32'h0000_0000;
					tries_reg  <= 2'h0;
					if (releasing) begin
						sj_state_reg <= CZA_SJ_WATCH;
					end
				end
				CZA_SJ_WATCH: begin
					if (!zone_photo_eye || !releasing) begin
						sj_state_reg <= CZA_SJ_IDLE;
					end else if (sj_cnt_reg >= jam_time_reg) begin
						sj_cnt_reg   <= 32'h0000_0000;
						sj_state_reg <= ctrl_reg[`CZA_CTRL_SAC_EN]
							? CZA_SJ_REVERSE : CZA_SJ_STUCK;
					end else if (tick) begin
						sj_cnt_reg <= sj_cnt_reg + 32'h0000_0001;
					end
				end
				CZA_SJ_REVERSE: begin
					if (!zone_photo_eye || sj_cnt_reg >= 32'(`CZA_REV_MS)) begin
						sj_cnt_reg   <= 32'h0000_0000;
						sj_state_reg <= CZA_SJ_WAIT;
					end else if (tick) begin
						sj_cnt_reg <= sj_cnt_reg + 32'h0000_0001;
					end
				end
				CZA_SJ_WAIT: begin
					if (sj_cnt_reg >= clr_time_reg) begin
						sj_cnt_reg   <= 32'h0000_0000;
						sj_state_reg <= CZA_SJ_FORWARD;
					end else if (tick) begin
						sj_cnt_reg <= sj_cnt_reg + 32'h0000_0001;
					end
				end
				CZA_SJ_FORWARD: begin
					// Forward run lasts one jam time; a clear sensor ends it early
					if (!zone_photo_eye) begin
						sj_state_reg <= CZA_SJ_IDLE;
					end else if (sj_cnt_reg >= jam_time_reg) begin
						sj_cnt_reg <= 32'h0000_0000;
						tries_reg  <= tries_reg + 2'h1;
						sj_state_reg <= (tries_reg == 2'(`CZA_ATTEMPTS - 1))
							? CZA_SJ_STUCK : CZA_SJ_REVERSE;
					end else if (tick) begin
						sj_cnt_reg <= sj_cnt_reg + 32'h0000_0001;
					end
				end
				CZA_SJ_STUCK: begin
					sj_cnt_reg <= 32'h0000_0000;
					if (!zone_photo_eye) begin
						sj_state_reg <= CZA_SJ_IDLE;
					end else if (recover_req) begin
						tries_reg    <= 2'h0;
						sj_state_reg <= CZA_SJ_REVERSE;
					end
				end
				default: sj_state_reg <= CZA_SJ_IDLE;
			endcase
		end
	end

	// LED blink period of about half a second
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			blink_reg <= 9'h000;
		end else if (tick) begin
			blink_reg <= blink_reg + 9'h001;
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			motor       <= '0;
			upstream_link <= '0;
			sensor_led  <= 1'b0;
		end else begin
			motor.rev <= sj_state_reg == CZA_SJ_REVERSE;
			motor.fwd <= releasing || sj_state_reg == CZA_SJ_FORWARD
				|| (upstream_release && !zone_photo_eye);
			upstream_link.clear   <= !zone_photo_eye && !hold;
			upstream_link.arrived <= zone_photo_eye && !eye_q_reg;
			if (arr_jam_reg) begin
				sensor_led <= blink_reg[8];
			end else if (sj_state_reg != CZA_SJ_IDLE && sj_state_reg != CZA_SJ_WATCH) begin
				sensor_led <= 1'b1;
			end else begin
				sensor_led <= zone_photo_eye;
			end
		end
	end

endmodule

// ---- tb/cza_zone_monitor.sv ----
`timescale 1ns/1ps
module cza_zone_monitor
	import cza_pkg::*;
#(
	parameter int BLK_MIN = 190000
)
(
	input wire logic         clk_sys,
	input wire logic         reset,
	input wire cza_ahb_rsp_t ahb_rsp,
	input wire logic         zone_photo_eye,
	input wire cza_link_t    upstream_link,
	input wire cza_motor_t   motor,
	input wire logic         sensor_led
);
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (reset);
	// Saturates so a long blockage never wraps back under the bound
	logic [17:0] blk_cnt;
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset)
			blk_cnt <= '0;
		else if (!zone_photo_eye)
			blk_cnt <= '0;
		else if (blk_cnt != '1)
			blk_cnt <= blk_cnt + 18'h1;
	end
	sequence s_rev_held;
		motor.rev ##1 motor.rev;
	endsequence
	property p_ready; ahb_rsp.hreadyout && !ahb_rsp.hresp; endproperty
	a_ready: assert property (p_ready) else $error("bus slave not ready or not okay");
	property p_excl; !(motor.fwd && motor.rev); endproperty
	a_excl: assert property (p_excl) else $error("motor driven both ways");
	property p_arr_pulse; upstream_link.arrived |=> !upstream_link.arrived; endproperty
	a_arr_pulse: assert property (p_arr_pulse) else $error("arrival longer than a pulse");
	property p_arr_cause; $rose(zone_photo_eye) |-> ##[0:3] upstream_link.arrived; endproperty
	a_arr_cause: assert property (p_arr_cause) else $error("arrival not confirmed");
	property p_rev_cause; $rose(motor.rev) |-> blk_cnt >= BLK_MIN; endproperty
	a_rev_cause: assert property (p_rev_cause) else $error("sensor jam too early");
	property p_rev_stop; motor.rev && !zone_photo_eye |-> ##[1:3] !motor.rev; endproperty
	a_rev_stop: assert property (p_rev_stop) else $error("reverse past clear sensor");
	property p_led_jam; s_rev_held |-> sensor_led; endproperty
	a_led_jam: assert property (p_led_jam) else $error("jam not shown on led");
	property p_hold_up; zone_photo_eye [*3] |-> !upstream_link.clear; endproperty
	a_hold_up: assert property (p_hold_up) else $error("occupied zone accepts");
endmodule

bind cza_zone cza_zone_monitor #(.BLK_MIN(3)) u_mon (
	.clk_sys        (clk_sys),
	.reset          (reset),
	.ahb_rsp        (ahb_rsp),
	.zone_photo_eye (zone_photo_eye),
	.upstream_link  (upstream_link),
	.motor          (motor),
	.sensor_led     (sensor_led)
);

// ---- tb/cza_far_side.sv ----
`timescale 1ns/1ps
module cza_far_side
	import cza_pkg::*;
(
	input  wire logic       clk_sys,
	input  wire cza_motor_t motor,
	input  wire logic       load,
	input  wire logic       stuck,
	input  wire logic       confirm,
	input  wire logic       ds_free,
	output logic            zone_photo_eye,
	output logic            downstream_photo_eye,
	output cza_link_t       downstream_link,
	output logic            upstream_release
);
	// Cartons are one zone long, so flex handling is never overrun
	logic [7:0] run_cnt = 8'h0;
	logic [7:0] trip_cnt = 8'h0;
	logic       arr_reg = 1'b0;
	initial begin
		zone_photo_eye = 1'b0;
		downstream_photo_eye = 1'b0;
		upstream_release = 1'b0;
	end
	assign downstream_link = '{clear: ds_free && !downstream_photo_eye, arrived: arr_reg};
	always @(posedge clk_sys) begin
		upstream_release <= load;
		if (upstream_release)
			zone_photo_eye <= 1'b1;
		// A stuck carton only moves when backed off
		if (zone_photo_eye && (stuck ? motor.rev : motor.fwd))
			run_cnt <= run_cnt + 8'h1;
		else
			run_cnt <= 8'h0;
		if (run_cnt == 8'h14) begin
			zone_photo_eye <= 1'b0;
			trip_cnt <= {7'h0, !stuck};
		end else if (trip_cnt != 8'h0)
			trip_cnt <= (trip_cnt == 8'h1E) ? 8'h0 : trip_cnt + 8'h1;
		downstream_photo_eye <= trip_cnt >= 8'h14;
		arr_reg <= confirm && trip_cnt == 8'h14;
	end
endmodule

// ---- tb/conveyor_zone_accumulation_bench.sv ----
`timescale 1ns/1ps
`include "cza_defines.svh"
module conveyor_zone_accumulation_bench
	import cza_pkg::*;
;
	// Tests take a few thousand cycles; a millisecond tick never falls inside the run
	localparam int LIMIT = 20000;
	logic         clk_sys, reset, load, stuck, confirm, ds_free, nb_upd, eye, ds_eye, up_rel;
	logic         led;
	logic [31:0]  nb_data, rd;
	cza_ahb_req_t req, req_in;
	cza_ahb_rsp_t rsp;
	cza_link_t    ds_link, up_link;
	cza_motor_t   motor;
	int           fail_count = 0, n_checks = 0, cycles = 0;
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	always_comb begin
		req_in = req;
		req_in.hready = rsp.hreadyout;
	end
	cza_zone u_dut (.clk_sys(clk_sys), .reset(reset), .ahb_req(req_in), .ahb_rsp(rsp),
		.zone_photo_eye(eye), .downstream_photo_eye(ds_eye), .downstream_link(ds_link),
		.upstream_release(up_rel), .neighbour_update(nb_upd), .neighbour_data(nb_data),
		.upstream_link(up_link), .motor(motor), .sensor_led(led));
	cza_far_side u_far (.clk_sys(clk_sys), .motor(motor), .load(load), .stuck(stuck),
		.confirm(confirm), .ds_free(ds_free), .zone_photo_eye(eye),
		.downstream_photo_eye(ds_eye), .downstream_link(ds_link), .upstream_release(up_rel));
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
		req.hsel <= 1'b1;
		req.haddr <= a;
		req.htrans <= CZA_HTRANS_NONSEQ;
		req.hwrite <= wr;
		do @(posedge clk_sys); while (rsp.hreadyout !== 1'b1);
		req.htrans <= CZA_HTRANS_IDLE;
		req.hsel <= 1'b0;
		req.hwdata <= d;
		do @(posedge clk_sys); while (rsp.hreadyout !== 1'b1);
		rd = rsp.hrdata;
	endtask
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task automatic put;
		load <= 1'b1;
		@(posedge clk_sys);
		load <= 1'b0;
	endtask
	task automatic t_regs;
		bus(0, `CZA_OFF_CTRL, 0);
		chk("ctrl", `CZA_CTRL_RESET, rd);
		bus(0, `CZA_OFF_JAM_TIME, 0);
		chk("jam time", `CZA_JAM_MS, rd);
		bus(0, `CZA_OFF_CLR_TIME, 0);
		chk("clear time", `CZA_CLR_MS, rd);
		bus(0, 32'h0000_0040, 0);
		chk("unmapped", 32'h0, rd);
		// Nonzero timers never expire within the run; zero forces expiry
		bus(1, `CZA_OFF_JAM_TIME, 32'h2);
		bus(1, `CZA_OFF_CLR_TIME, 32'h2);
		bus(0, `CZA_OFF_JAM_TIME, 0);
		chk("jam time", 32'h2, rd);
		nb_data <= 32'hA5C3_0F12;
		nb_upd <= 1'b1;
		@(posedge clk_sys);
		nb_upd <= 1'b0;
		bus(0, `CZA_OFF_NEIGHBOUR, 0);
		chk("neighbour", 32'hA5C3_0F12, rd);
		$display("test regs done");
	endtask
	task automatic t_release;
		ds_free <= 1'b0;
		put;
		wait_cyc(2000);
		chk("held", 32'h0, {31'h0, motor.fwd});
		ds_free <= 1'b1;
		for (int i = 0; i < 200 && motor.fwd !== 1'b1; i++) @(posedge clk_sys);
		chk("release", 32'h1, {31'h0, motor.fwd});
		wait_cyc(200);
		bus(0, `CZA_OFF_STATUS, 0);
		chk("status", 32'h0, rd);
		$display("test release done");
	endtask
	task automatic t_arr_jam;
		confirm <= 1'b0;
		put;
		wait_cyc(200);
		put;
		wait_cyc(1000);
		chk("pending hold", 32'h0, {31'h0, motor.fwd});
		// Zero jam time expires the pending wait; restore before any release
		bus(1, `CZA_OFF_JAM_TIME, 32'h0);
		bus(1, `CZA_OFF_JAM_TIME, 32'h2);
		bus(0, `CZA_OFF_STATUS, 0);
		chk("arrival jam", 32'h8, rd & 32'h8);
		chk("jam hold", 32'h0, {31'h0, motor.fwd});
		confirm <= 1'b1;
		bus(1, `CZA_OFF_CLR_TIME, 32'h0);
		for (int i = 0; i < 200 && motor.fwd !== 1'b1; i++) @(posedge clk_sys);
		chk("auto release", 32'h1, {31'h0, motor.fwd});
		wait_cyc(200);
		bus(0, `CZA_OFF_STATUS, 0);
		chk("jam cleared", 32'h0, rd & 32'hC);
		$display("test arrival jam done");
	endtask
	task automatic t_sensor_jam;
		bus(1, `CZA_OFF_JAM_TIME, 32'h0);
		stuck <= 1'b1;
		put;
		for (int i = 0; i < 100 && motor.rev !== 1'b1; i++) @(posedge clk_sys);
		chk("reverse", 32'h1, {31'h0, motor.rev});
		chk("jam led", 32'h1, {31'h0, led});
		bus(0, `CZA_OFF_STATUS, 0);
		chk("sensor jam", 32'h10, rd & 32'h10);
		for (int i = 0; i < 100 && motor.rev === 1'b1; i++) @(posedge clk_sys);
		chk("reverse stop", 32'h0, {31'h0, motor.rev});
		wait_cyc(10);
		bus(0, `CZA_OFF_STATUS, 0);
		chk("jam reset", 32'h0, rd & 32'h10);
		$display("test sensor jam done");
	endtask
	task automatic t_stuck;
		// Auto-clear off sends a sensor jam straight to the stuck state
		bus(1, `CZA_OFF_CTRL, 32'h3);
		put;
		wait_cyc(20);
		bus(0, `CZA_OFF_STATUS, 0);
		chk("stuck status", 32'h31, rd);
		chk("stuck motor", 32'h0, {30'h0, motor});
		bus(1, `CZA_OFF_CMD, 32'h1);
		for (int i = 0; i < 100 && motor.rev !== 1'b1; i++) @(posedge clk_sys);
		chk("recover", 32'h1, {31'h0, motor.rev});
		for (int i = 0; i < 100 && motor.rev === 1'b1; i++) @(posedge clk_sys);
		wait_cyc(10);
		bus(0, `CZA_OFF_STATUS, 0);
		chk("recovered", 32'h0, rd);
		stuck <= 1'b0;
		$display("test stuck done");
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			fail_count++;
			complete_run;
		end
	end
	initial begin
		reset = 1'b1;
		req = '0;
		req.hsize = 3'h2;
		{load, stuck, nb_upd, nb_data} = '0;
		{confirm, ds_free} = 2'h3;
		repeat (5) @(posedge clk_sys);
		reset <= 1'b0;
		@(posedge clk_sys);
		t_regs;
		t_release;
		t_arr_jam;
		t_sensor_jam;
		t_stuck;
		complete_run;
	end
endmodule
